// ### rtl/self_program_pkg.sv
// package: constants, types and layouts for the self-programming control block
package self_program_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] CTRL_IO_ADDR = 8'h37;
   localparam logic [7:0] CTRL_MEM_ADDR = 8'h57;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int BIT_IRQ_EN = 7;
   localparam int BIT_BUSY = 6;
   localparam int BIT_RESERVED = 5;
   localparam int BIT_REENABLE = 4;
   localparam int BIT_LOCK_SET = 3;
   localparam int BIT_PAGE_WRITE = 2;
   localparam int BIT_PAGE_ERASE = 1;
   localparam int BIT_STORE_EN = 0;

   // accepted low five-bit command patterns
   localparam logic [4:0] PAT_REENABLE = 5'h11;
   localparam logic [4:0] PAT_LOCK_SET = 5'h09;
   localparam logic [4:0] PAT_PAGE_WRITE = 5'h05;
   localparam logic [4:0] PAT_PAGE_ERASE = 5'h03;
   localparam logic [4:0] PAT_BUF_FILL = 5'h01;

   // ------------------------------------------------------------------
   // flash geometry
   // ------------------------------------------------------------------
   localparam int COUNTER_TOP_BIT = 13;
   localparam int PAGE_WORD_TOP_BIT = 5;
   localparam int POINTER_COUNTER_TOP_BIT = 14;
   localparam int POINTER_PAGE_TOP_BIT = 6;
   localparam int PAGE_WORDS = 64;
   localparam logic [13:0] NO_READWHILEWRITE_REGION_START = 14'h3800;
   localparam logic [13:0] RWW_END = 14'h37ff;
   localparam logic [13:0] BOOT_START_256 = 14'h3f00;
   localparam logic [13:0] BOOT_START_512 = 14'h3e00;
   localparam logic [13:0] BOOT_START_1024 = 14'h3c00;
   localparam logic [13:0] BOOT_START_2048 = 14'h3800;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int ARM_WINDOW_CYCLES = 4;
   localparam int PROG_TIME_US = 3700;
   localparam int CLK_MHZ = 100;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_PROG = 2'b10
   } seq_state_e;

   typedef struct packed
   {
      logic [13:0] word_addr;
      logic [15:0] data;
   } buf_write_s;

endpackage

// ### rtl/page_buffer_mem.sv
// memory: temporary page buffer, 64 words with registered read
`timescale 1ns/10ps
module page_buffer_mem
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // write port
   input wire logic wr_en,
   input wire logic [5:0] wr_idx,
   input wire logic [15:0] wr_data,
   input wire logic clear,
   // read port
   input wire logic [5:0] rd_idx,
   output logic [15:0] rd_data,
   output logic [63:0] filled
);

   logic [15:0] mem [0:63];

   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         mem[wr_idx] <= wr_data;
      end
   end

   // an aborted or never-loaded word reads as zero, so discarded data cannot leak out
   always_ff @(posedge clk_sys)
   begin
      rd_data <= filled[rd_idx] ? mem[rd_idx] : 16'h0000;
   end

   // a clear drops every word by its valid bit; data cells keep stale content
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         filled <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         // a load in the same cycle as a clear survives it
         if (clear)
         begin
            filled <= 64'h0000_0000_0000_0000;
         end
         if (wr_en)
         begin
            filled[wr_idx] <= 1'b1;
         end
      end
   end

endmodule

// ### rtl/boot_self_program_control.sv
// main module: control register, command sequencing and region access
`timescale 1ns/10ps
module boot_self_program_control
#(
   parameter int PROG_CYCLES = self_program_pkg::PROG_CYCLES
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // io port from core
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_addr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // store instruction
   input wire logic store_exec,
   input wire logic [15:0] pointer_z,
   input wire logic [15:0] store_data,
   // status from core and fuses
   input wire logic global_irq_en,
   input wire logic [1:0] boot_size_fuse,
   // fetch and read checks
   input wire logic [13:0] fetch_addr,
   output logic fetch_allowed,
   // outputs
   output logic ready_irq,
   output logic core_halt,
   output logic [13:0] boot_start,
   output logic [15:0] buf_rd_data,
   output logic prog_erase,
   output logic prog_write,
   output logic [7:0] prog_page
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   self_program_pkg::seq_state_e state_r;
   logic [4:0] cmd_r, wr_pat;
   logic [1:0] win_r;
   logic [31:0] prog_cnt_r;
   logic [7:0] page_r, ctrl_view;
   logic irq_en_r, busy_r, prog_no_readwhilewrite_region_r, is_write_r, fill_active_r;
   logic wr_hit, pat_ok, store_go, buf_wr, buf_clr, prog_start, prog_done;
   self_program_pkg::buf_write_s bw;
   function automatic logic in_no_readwhilewrite_region(input logic [13:0] a);
      in_no_readwhilewrite_region = (a >= self_program_pkg::NO_READWHILEWRITE_REGION_START);
   endfunction
   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   assign wr_hit = io_wr && (io_addr == self_program_pkg::CTRL_IO_ADDR);
   assign wr_pat = io_wdata[4:0];
   assign pat_ok = (wr_pat == self_program_pkg::PAT_REENABLE)
                || (wr_pat == self_program_pkg::PAT_LOCK_SET)
                || (wr_pat == self_program_pkg::PAT_PAGE_WRITE)
                || (wr_pat == self_program_pkg::PAT_PAGE_ERASE)
                || (wr_pat == self_program_pkg::PAT_BUF_FILL);
   assign store_go = store_exec && (state_r == self_program_pkg::ST_ARMED);
   assign bw.word_addr = pointer_z[14:1];
   assign bw.data = store_data;
   assign buf_wr = store_go && (cmd_r == self_program_pkg::PAT_BUF_FILL);
   // a re-enable write after a buffer load (fill_active_r set) aborts the fill, whatever the state
   assign buf_clr = (wr_hit && pat_ok && (wr_pat == self_program_pkg::PAT_REENABLE)
                     && fill_active_r)
                 || (store_go && (cmd_r == self_program_pkg::PAT_PAGE_WRITE));
   assign prog_start = store_go && ((cmd_r == self_program_pkg::PAT_PAGE_WRITE)
                                 || (cmd_r == self_program_pkg::PAT_PAGE_ERASE));
   assign prog_done = (state_r == self_program_pkg::ST_PROG)
                   && (prog_cnt_r == 32'(PROG_CYCLES - 1));
   // ------------------------------------------------------------------
   // command sequencer
   // ------------------------------------------------------------------
   // store enable (cmd_r[0]) is taken only while idle, so writes mid-run cannot disturb it
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         state_r <= self_program_pkg::ST_IDLE;
         cmd_r <= 5'h00;
         win_r <= 2'h0;
      end
      else
      begin
         unique case (state_r)
            self_program_pkg::ST_IDLE:
            begin
               if (wr_hit && pat_ok)
               begin
                  state_r <= self_program_pkg::ST_ARMED;
                  cmd_r <= wr_pat;
                  win_r <= 2'h0;
               end
            end
            self_program_pkg::ST_ARMED:
            begin
               if (prog_start)
               begin
                  state_r <= self_program_pkg::ST_PROG;
               end
               else if (store_go || (win_r == 2'(self_program_pkg::ARM_WINDOW_CYCLES - 1)))
               begin
                  state_r <= self_program_pkg::ST_IDLE;
                  cmd_r <= 5'h00;
               end
               else
               begin
                  win_r <= win_r + 2'h1;
               end
            end
            self_program_pkg::ST_PROG:
            begin
               if (prog_done)
               begin
                  state_r <= self_program_pkg::ST_IDLE;
                  cmd_r <= 5'h00;
               end
            end
            default:
            begin
               state_r <= self_program_pkg::ST_IDLE;
               cmd_r <= 5'h00;
            end
         endcase
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (srst || (state_r != self_program_pkg::ST_PROG))
      begin
         prog_cnt_r <= 32'h0000_0000;
      end
      else
      begin
         prog_cnt_r <= prog_cnt_r + 32'h0000_0001;
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         page_r <= 8'h00;
         prog_no_readwhilewrite_region_r <= 1'b0;
         is_write_r <= 1'b0;
      end
      else if (prog_start)
      begin
         page_r <= pointer_z[14:7];
         prog_no_readwhilewrite_region_r <= in_no_readwhilewrite_region({pointer_z[14:7], 6'h00});
         is_write_r <= (cmd_r == self_program_pkg::PAT_PAGE_WRITE);
      end
   end
   // a load in the same cycle as an abort wins, matching the buffer's valid bits
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         fill_active_r <= 1'b0;
      end
      else if (buf_wr)
      begin
         fill_active_r <= 1'b1;
      end
      else if (buf_clr)
      begin
         fill_active_r <= 1'b0;
      end
   end
   // ------------------------------------------------------------------
   // busy flag and interrupt enable
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         busy_r <= 1'b0;
      end
      else if (prog_start && !in_no_readwhilewrite_region({pointer_z[14:7], 6'h00}))
      begin
         busy_r <= 1'b1;
      end
      else if (buf_wr || (store_go && (cmd_r == self_program_pkg::PAT_REENABLE)))
      begin
         busy_r <= 1'b0;
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         irq_en_r <= 1'b0;
      end
      else if (wr_hit)
      begin
         irq_en_r <= io_wdata[self_program_pkg::BIT_IRQ_EN];
      end
   end
   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign ctrl_view = {irq_en_r, busy_r, 1'b0, cmd_r}; // bit 5 tied to zero
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         io_rdata <= self_program_pkg::CTRL_RESET;
      end
      else if (io_rd && (io_addr == self_program_pkg::CTRL_IO_ADDR))
      begin
         io_rdata <= ctrl_view;
      end
   end
   assign ready_irq = irq_en_r && global_irq_en && !cmd_r[self_program_pkg::BIT_STORE_EN];
   assign fetch_allowed = in_no_readwhilewrite_region(fetch_addr) || !busy_r;
   assign core_halt = (state_r == self_program_pkg::ST_PROG) && prog_no_readwhilewrite_region_r;
   assign prog_erase = (state_r == self_program_pkg::ST_PROG) && !is_write_r;
   assign prog_write = (state_r == self_program_pkg::ST_PROG) && is_write_r;
   assign prog_page = page_r;
   always_comb
   begin
      unique case (boot_size_fuse)
         2'b11: boot_start = self_program_pkg::BOOT_START_256;
         2'b10: boot_start = self_program_pkg::BOOT_START_512;
         2'b01: boot_start = self_program_pkg::BOOT_START_1024;
         2'b00: boot_start = self_program_pkg::BOOT_START_2048;
      endcase
   end
   page_buffer_mem u_buf
   (
      .clk_sys(clk_sys),
      .srst(srst),
      .wr_en(buf_wr),
      .wr_idx(bw.word_addr[5:0]),
      .wr_data(bw.data),
      .clear(buf_clr),
      .rd_idx(pointer_z[6:1]),
      .rd_data(buf_rd_data),
      .filled()
   );
   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   a_busy_sets: assert property (@(posedge clk_sys) disable iff (srst)
      (prog_start && !in_no_readwhilewrite_region({pointer_z[14:7], 6'h00})) |=> busy_r)
      else $error("busy not set by rww programming");
   a_fill_clears: assert property (@(posedge clk_sys) disable iff (srst)
      buf_wr |=> !busy_r)
      else $error("busy not cleared by buffer load");
   a_window_expires: assert property (@(posedge clk_sys) disable iff (srst)
      (state_r == self_program_pkg::ST_ARMED && !store_exec) [*4]
      |=> state_r == self_program_pkg::ST_IDLE)
      else $error("armed state outlived four cycles");
   a_irq_level: assert property (@(posedge clk_sys) disable iff (srst)
      (irq_en_r && global_irq_en && !cmd_r[0]) |-> ready_irq)
      else $error("ready irq missing");
   a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (srst)
      $past(io_rd) |-> !io_rdata[self_program_pkg::BIT_RESERVED])
      else $error("reserved bit read as one");
   a_bad_pattern: assert property (@(posedge clk_sys) disable iff (srst)
      (wr_hit && !pat_ok && state_r == self_program_pkg::ST_IDLE)
      |=> state_r == self_program_pkg::ST_IDLE)
      else $error("bad pattern armed a command");
   a_prog_holds: assert property (@(posedge clk_sys) disable iff (srst)
      (state_r == self_program_pkg::ST_PROG && !prog_done) |=> cmd_r[0])
      else $error("store enable dropped during programming");
   a_region_block: assert property (@(posedge clk_sys) disable iff (srst)
      (busy_r && fetch_addr <= self_program_pkg::RWW_END) |-> !fetch_allowed)
      else $error("rww fetch allowed while busy");
   a_reenable_clears: assert property (@(posedge clk_sys) disable iff (srst)
      (store_go && cmd_r == self_program_pkg::PAT_REENABLE) |=> !busy_r)
      else $error("re-enable did not clear busy");
endmodule

// ### dv/core_model.sv
// model: processor core driving io accesses and store instructions
`timescale 1ns/10ps
module core_model
(
   // clock
   input wire logic clk_sys,
   // io port
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_addr,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   // store instruction
   output logic store_exec,
   output logic [15:0] pointer_z,
   output logic [15:0] store_data,
   output logic global_irq_en,
   input wire logic [15:0] buf_rd_data
);
   // no eeprom here, so its write-in-progress flag never rises
   logic eeprom_write_active = 1'b0;
   initial
   begin
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_addr = 8'h00;
      io_wdata = 8'h00;
      store_exec = 1'b0;
      pointer_z = 16'h0000;
      store_data = 16'h0000;
      global_irq_en = 1'b1;
   end
   task automatic io_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      io_wr = 1'b1;
      io_addr = a;
      io_wdata = d;
      @(posedge clk_sys);
      #1;
      io_wr = 1'b0;
      io_addr = ~a;
      io_wdata = ~d;
   endtask
   task automatic io_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1;
      io_rd = 1'b1;
      io_addr = a;
      @(posedge clk_sys);
      #1;
      io_rd = 1'b0;
      io_addr = ~a;
      d = io_rdata;
   endtask
   // released operands are inverted so stale values never look valid
   task automatic store(input logic [15:0] z, input logic [15:0] d);
      @(posedge clk_sys);
      #1;
      store_exec = 1'b1;
      pointer_z = z;
      store_data = d;
      @(posedge clk_sys);
      #1;
      store_exec = 1'b0;
      pointer_z = ~z;
      store_data = ~d;
   endtask
   task automatic peek(input logic [15:0] z, output logic [15:0] d);
      pointer_z = z;
      repeat (2) @(posedge clk_sys);
      #1;
      d = buf_rd_data;
   endtask
   task automatic wait_idle;
      logic [7:0] st;
      int n;
      st = 8'hff;
      n = 0;
      while (st[0] !== 1'b0 && n < 100)
      begin
         io_read(8'h37, st);
         n++;
      end
   endtask
   // full timed sequence; the page write pointer keeps word index zero
   task automatic spm(input logic [7:0] cmd, input logic [15:0] z, input logic [15:0] d);
      logic irq_save;
      wait_idle();
      irq_save = global_irq_en;
      global_irq_en = 1'b0;
      while (eeprom_write_active) @(posedge clk_sys);
      io_write(8'h37, cmd);
      store(z, d);
      global_irq_en = irq_save;
   endtask
endmodule

// ### dv/boot_self_program_control_bench.sv
// bench: directed tests of the self-programming control block
`timescale 1ns/10ps
module boot_self_program_control_bench;
   logic clk_sys, srst, io_wr, io_rd, store_exec, global_irq_en, fetch_allowed;
   logic ready_irq, core_halt, prog_erase, prog_write;
   logic [7:0] io_addr, io_wdata, io_rdata, prog_page;
   logic [15:0] pointer_z, store_data, buf_rd_data, w;
   logic [1:0] boot_size_fuse;
   logic [13:0] fetch_addr, boot_start;
   logic [13:0] starts [4] = '{14'h3800, 14'h3c00, 14'h3e00, 14'h3f00};
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   boot_self_program_control #(.PROG_CYCLES(20)) i_dut
   (
      .clk_sys(clk_sys), .srst(srst), .io_wr(io_wr), .io_rd(io_rd),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .store_exec(store_exec), .pointer_z(pointer_z), .store_data(store_data),
      .global_irq_en(global_irq_en), .boot_size_fuse(boot_size_fuse),
      .fetch_addr(fetch_addr), .fetch_allowed(fetch_allowed), .ready_irq(ready_irq),
      .core_halt(core_halt), .boot_start(boot_start), .buf_rd_data(buf_rd_data),
      .prog_erase(prog_erase), .prog_write(prog_write), .prog_page(prog_page)
   );
   core_model i_core
   (
      .clk_sys(clk_sys), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .store_exec(store_exec),
      .pointer_z(pointer_z), .store_data(store_data),
      .global_irq_en(global_irq_en), .buf_rd_data(buf_rd_data)
   );
   // ------------------------------------------------------------------
   // checking
   // ------------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rd_chk(input logic [7:0] exp);
      logic [7:0] d;
      i_core.io_read(8'h37, d);
      check("ctrl", 16'(d), 16'(exp));
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // limit well above the fewer than two hundred cycles the sequence needs
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors++;
         final_report();
      end
   end
   // ------------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------------
   initial
   begin
      srst = 1'b1;
      boot_size_fuse = 2'b11;
      fetch_addr = 14'h0100;
      repeat (10) @(posedge clk_sys);
      #1;
      srst = 1'b0;
      rd_chk(8'h00);
      for (int i = 0; i < 4; i++)
      begin
         boot_size_fuse = 2'(i);
         @(posedge clk_sys);
         #1;
         check("boot_start", 16'(boot_start), 16'(starts[i]));
      end
      i_core.io_write(8'h37, 8'hff);
      rd_chk(8'h80);
      check("ready_irq", 16'(ready_irq), 16'h0001);
      i_core.global_irq_en = 1'b0;
      @(posedge clk_sys);
      #1;
      check("ready_irq", 16'(ready_irq), 16'h0000);
      i_core.global_irq_en = 1'b1;
      i_core.io_write(8'h37, 8'h09);
      rd_chk(8'h09);
      repeat (5) @(posedge clk_sys);
      rd_chk(8'h00);
      i_core.spm(8'h01, 16'h000a, 16'ha5a5);
      rd_chk(8'h00);
      i_core.peek(16'h000a, w);
      check("buf", w, 16'ha5a5);
      // store arriving after the window closed must be ignored
      i_core.io_write(8'h37, 8'h01);
      repeat (6) @(posedge clk_sys);
      i_core.store(16'h000a, 16'h1234);
      i_core.peek(16'h000a, w);
      check("late_store", w, 16'ha5a5);
      i_core.spm(8'h83, 16'h0180, 16'h0000);
      rd_chk(8'hc3);
      check("erase", 16'(prog_erase), 16'h0001);
      check("page", 16'(prog_page), 16'h0003);
      check("ready_irq", 16'(ready_irq), 16'h0000);
      check("halt", 16'(core_halt), 16'h0000);
      check("fetch_rww", 16'(fetch_allowed), 16'h0000);
      fetch_addr = 14'h3800;
      @(posedge clk_sys);
      #1;
      check("fetch_no_readwhilewrite_region", 16'(fetch_allowed), 16'h0001);
      i_core.io_write(8'h37, 8'h91);
      i_core.store(16'h0000, 16'h0000);
      rd_chk(8'hc3);
      i_core.wait_idle();
      rd_chk(8'hc0);
      check("ready_irq", 16'(ready_irq), 16'h0001);
      fetch_addr = 14'h37ff;
      @(posedge clk_sys);
      #1;
      check("fetch_edge", 16'(fetch_allowed), 16'h0000);
      i_core.spm(8'h11, 16'h0000, 16'h0000);
      rd_chk(8'h00);
      check("fetch_edge", 16'(fetch_allowed), 16'h0001);
      i_core.spm(8'h05, 16'h7800, 16'h0000);
      rd_chk(8'h05);
      check("write", 16'(prog_write), 16'h0001);
      check("page", 16'(prog_page), 16'h00f0);
      check("halt", 16'(core_halt), 16'h0001);
      i_core.spm(8'h05, 16'h0100, 16'h0000);
      i_core.wait_idle();
      rd_chk(8'h40);
      i_core.spm(8'h01, 16'h000e, 16'h5a5a);
      rd_chk(8'h00);
      i_core.peek(16'h000e, w);
      check("buf", w, 16'h5a5a);
      // a re-enable write during a fill throws the loaded words away
      i_core.io_write(8'h37, 8'h11);
      i_core.peek(16'h000e, w);
      check("abort", w, 16'h0000);
      final_report();
   end
endmodule
